//--- rtl/dcac_pkg.sv
// Constants and types shared by the drive command interpreter and its analog channels
package dcac_pkg;
    // Two-letter command codes, ASCII high letter first
    localparam logic [15:0] CMD_RAMP      = 16'h4143;
    localparam logic [15:0] CMD_DEADBAND  = 16'h4144;
    localparam logic [15:0] CMD_SMOOTH    = 16'h4146;
    localparam logic [15:0] CMD_PERSIST   = 16'h5341;
    localparam logic [15:0] CMD_REG_LOAD  = 16'h524C;
    localparam logic [15:0] CMD_REG_FETCH = 16'h5258;

    // Ramp rate held as a count of 0.167 rps/s steps (0.167 to 5461.067 rps/s)
    localparam logic [15:0] ACC_MIN       = 16'h0001;
    localparam logic [15:0] ACC_MAX       = 16'h7FBD;
    localparam logic [15:0] ACC_RESET     = 16'h0258;
    // Acceleration data register counts quarter steps
    localparam int unsigned ACC_REG_SHIFT = 2;

    // Deadband in millivolts, 0 to 255, per channel
    localparam logic [7:0]  DB_RESET      = 8'h00;
    localparam logic [1:0]  CHAN_FIRST    = 2'h1;
    localparam logic [1:0]  CHAN_LAST     = 2'h3;
    localparam int unsigned NUM_CHAN      = 3;

    // Smoothing setting, 0 bypasses; coefficient is capped above the knee
    localparam logic [15:0] FILT_MAX      = 16'h7FFF;
    localparam logic [15:0] FILT_CAP      = 16'h6E6F;
    localparam logic [15:0] FILT_RESET    = 16'h0000;
    localparam int unsigned FILT_FRAC     = 15;

    // Analog positioning mode number
    localparam logic [7:0]  MODE_ANALOG_POS = 8'h16;

    // Data register indices
    localparam logic [7:0]  REG_IDX_ACCEL  = 8'h11;
    localparam logic [7:0]  REG_IDX_ANALOG = 8'h2F;

    localparam int unsigned ADC_W   = 16;
    localparam int unsigned PARAM_W = 32;

    typedef enum logic [1:0] {
        USE_READ_ONLY  = 2'h0,
        USE_READ_WRITE = 2'h1,
        USE_WRITE_ONLY = 2'h2
    } dcac_usage_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } dcac_state_t;
endpackage

//--- rtl/dcac_chan.sv
// One analog channel: single-pole smoothing, zero shift and deadband or hysteresis
`timescale 1ns/1ns
module dcac_chan
    import dcac_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Sample stream
    input  wire logic                    sampleValid,
    input  wire logic signed [ADC_W-1:0] sample,
    input  wire logic signed [ADC_W-1:0] zeroPoint,
    // Settings
    input  wire logic [15:0]             smoothSetting,
    input  wire logic [7:0]              deadband,
    input  wire logic                    hystMode,
    // Conditioned value
    output logic signed [ADC_W:0]        condOut_q
);
    logic signed [31:0]    acc_q;
    logic signed [31:0]    acc_d;
    logic signed [ADC_W:0] cond_d;
    logic signed [31:0]    target;
    logic signed [32:0]    diff;
    logic signed [48:0]    prod;
    logic [15:0]           coef;
    logic signed [ADC_W:0] centered;
    logic [ADC_W:0]        mag;
    logic signed [ADC_W+1:0] drift;
    logic [ADC_W+1:0]      driftMag;
    logic signed [ADC_W-1:0] filt;

    assign filt = acc_q[30:15];

    always_comb begin
        target   = {{1{sample[ADC_W-1]}}, sample, 15'h0000};
        diff     = 33'(target) - 33'(acc_q);
        // Beyond the knee the pole barely moves, so the coefficient saturates
        coef     = (smoothSetting > FILT_CAP) ? FILT_CAP : smoothSetting;
        prod     = 49'(diff) * 49'($signed({1'b0, coef}));
        acc_d    = acc_q;
        if (sampleValid) begin
            if (smoothSetting == 16'h0000) begin
                acc_d = target;
            end else begin
                acc_d = acc_q + 32'(prod >>> FILT_FRAC);
            end
        end
        centered = 17'(filt) - 17'(zeroPoint);
        mag      = centered[ADC_W] ? 17'(-centered) : 17'(centered);
        drift    = 18'(centered) - 18'(condOut_q);
        driftMag = drift[ADC_W+1] ? 18'(-drift) : 18'(drift);
        if (hystMode) begin
            // Follows only once the input has moved more than the deadband value away from the held output
            cond_d = (driftMag > {10'h000, deadband}) ? centered : condOut_q;
        end else begin
            cond_d = (mag <= {9'h000, deadband}) ? 17'sh0_0000 : centered;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q     <= 32'sh0000_0000;
            condOut_q <= 17'sh0_0000;
        end else begin
            acc_q     <= acc_d;
            condOut_q <= cond_d;
        end
    end

    AST_DEADBAND_ZERO: assert property (@(posedge clk) disable iff (rst)
        !hystMode && (mag <= {9'h000, deadband}) |=> condOut_q == 17'sh0_0000)
        else $error("reading inside deadband not forced to zero");

    AST_FILTER_BYPASS: assert property (@(posedge clk) disable iff (rst)
        sampleValid && smoothSetting == 16'h0000 |=> filt == $past(sample))
        else $error("zero smoothing setting did not bypass filter");
endmodule

//--- rtl/dcac_cmd_top.sv
// Command interpreter for ramp rate, analog deadband and analog smoothing
`timescale 1ns/1ns
module dcac_cmd_top
    import dcac_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Parsed command from the host link
    input  wire logic                    cmdValid,
    input  wire logic [15:0]             cmdCode,
    input  wire logic                    cmdHasParam,
    input  wire logic                    cmdHasParam2,
    input  wire logic signed [31:0]      cmdParam1,
    input  wire logic signed [31:0]      cmdParam2,
    output logic                         cmdReady_q,
    // Reply and command class
    output logic                         rspValid_q,
    output logic [15:0]                  rspCode_q,
    output logic signed [31:0]           rspValue_q,
    output logic                         cmdErr_q,
    output logic                         cmdImmediate_q,
    output logic [1:0]                   cmdUsage_q,
    // Analog path
    input  wire logic [7:0]              controlModeSelect,
    input  wire logic                    adcValid,
    input  wire logic signed [ADC_W-1:0] adcCh1,
    input  wire logic signed [ADC_W-1:0] adcCh2,
    input  wire logic signed [ADC_W-1:0] zeroPoint,
    output logic signed [ADC_W:0]        analogCmd_q,
    // Working settings
    output logic [15:0]                  rampRateSetting_q,
    output logic [31:0]                  accelReg_q,
    output logic [15:0]                  inputSmoothingSetting_q,
    // Persistent copy
    output logic                         nvWrite_q,
    output logic [15:0]                  nvRampRate_q,
    output logic [15:0]                  nvSmoothing_q,
    output logic [NUM_CHAN*8-1:0]        nvDeadband_q
);
    dcac_state_t           state_q;
    dcac_state_t           state_d;
    logic [15:0]           code_q;
    logic [15:0]           code_d;
    logic                  hasP_q;
    logic                  hasP_d;
    logic                  hasP2_q;
    logic                  hasP2_d;
    logic signed [31:0]    par1_q;
    logic signed [31:0]    par1_d;
    logic signed [31:0]    par2_q;
    logic signed [31:0]    par2_d;
    logic                  ready_d;
    logic                  rspValid_d;
    logic [15:0]           rspCode_d;
    logic signed [31:0]    rspValue_d;
    logic                  err_d;
    logic                  imm_d;
    logic [1:0]            usage_d;
    logic [15:0]           ramp_d;
    logic [15:0]           smooth_d;
    logic [7:0]            db_q [NUM_CHAN];
    logic [7:0]            db_d [NUM_CHAN];
    logic                  nvWrite_d;
    logic                  p1Fits16;
    logic                  p2Fits8;
    logic                  exec;
    logic signed [ADC_W-1:0] diffSample;
    logic signed [ADC_W:0]   diffWide;
    logic signed [ADC_W-1:0] chanSample [NUM_CHAN];
    logic signed [ADC_W:0]   chanOut [NUM_CHAN];
    logic                  hystMode;

    assign exec     = (state_q == ST_EXEC);
    assign p1Fits16 = (par1_q[31:16] == 16'h0000);
    assign p2Fits8  = (par2_q[31:8] == 24'h00_0000);
    assign hystMode = (controlModeSelect == MODE_ANALOG_POS);

    // Differential channel saturates rather than wrapping
    always_comb begin
        diffWide = 17'(adcCh1) - 17'(adcCh2);
        if (diffWide[ADC_W] != diffWide[ADC_W-1]) begin
            diffSample = diffWide[ADC_W] ? 16'sh8000 : 16'sh7FFF;
        end else begin
            diffSample = diffWide[ADC_W-1:0];
        end
    end

    assign chanSample[0] = adcCh1;
    assign chanSample[1] = adcCh2;
    assign chanSample[2] = diffSample;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : gChan
            dcac_chan uChan (
                .clk           (clk),
                .rst           (rst),
                .sampleValid   (adcValid),
                .sample        (chanSample[gi]),
                .zeroPoint     (zeroPoint),
                .smoothSetting (inputSmoothingSetting_q),
                .deadband      (db_q[gi]),
                .hystMode      (hystMode),
                .condOut_q     (chanOut[gi])
            );
        end
    endgenerate

    // Command sequencing and parameter store
    always_comb begin
        state_d    = state_q;
        code_d     = code_q;
        hasP_d     = hasP_q;
        hasP2_d    = hasP2_q;
        par1_d     = par1_q;
        par2_d     = par2_q;
        ready_d    = cmdReady_q;
        rspValid_d = 1'b0;
        rspCode_d  = rspCode_q;
        rspValue_d = rspValue_q;
        err_d      = 1'b0;
        imm_d      = cmdImmediate_q;
        usage_d    = cmdUsage_q;
        ramp_d     = rampRateSetting_q;
        smooth_d   = inputSmoothingSetting_q;
        db_d       = db_q;
        nvWrite_d  = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                ready_d = 1'b1;
                if (cmdValid && cmdReady_q) begin
                    code_d  = cmdCode;
                    hasP_d  = cmdHasParam;
                    hasP2_d = cmdHasParam && cmdHasParam2;
                    par1_d  = cmdParam1;
                    par2_d  = cmdParam2;
                    ready_d = 1'b0;
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_d   = ST_IDLE;
                ready_d   = 1'b1;
                rspCode_d = code_q;
                imm_d     = 1'b0;
                usage_d   = USE_READ_WRITE;
                unique case (code_q)
                    CMD_RAMP: begin
                        if (!hasP_q) begin
                            rspValid_d = 1'b1;
                            rspValue_d = 32'(rampRateSetting_q);
                        end else if (p1Fits16 && par1_q[15:0] >= ACC_MIN
                                     && par1_q[15:0] <= ACC_MAX) begin
                            ramp_d = par1_q[15:0];
                        end else begin
                            err_d = 1'b1;
                        end
                    end
                    CMD_DEADBAND: begin
                        if (!hasP_q) begin
                            rspValid_d = 1'b1;
                            rspValue_d = 32'(db_q[0]);
                        end else if (hasP2_q) begin
                            // Channel form: first parameter picks the input
                            if (par1_q >= 32'sd1 && par1_q <= 32'sd3 && p2Fits8) begin
                                db_d[par1_q[1:0] - CHAN_FIRST] = par2_q[7:0];
                            end else begin
                                err_d = 1'b1;
                            end
                        end else if (par1_q[31:8] == 24'h00_0000) begin
                            // Single form sets every channel alike
                            for (int i = 0; i < NUM_CHAN; i++) begin
                                db_d[i] = par1_q[7:0];
                            end
                        end else begin
                            err_d = 1'b1;
                        end
                    end
                    CMD_SMOOTH: begin
                        if (!hasP_q) begin
                            rspValid_d = 1'b1;
                            rspValue_d = 32'(inputSmoothingSetting_q);
                        end else if (p1Fits16 && par1_q[15:0] <= FILT_MAX) begin
                            smooth_d = par1_q[15:0];
                        end else begin
                            err_d = 1'b1;
                        end
                    end
                    CMD_PERSIST: begin
                        usage_d   = USE_WRITE_ONLY;
                        nvWrite_d = 1'b1;
                    end
                    CMD_REG_LOAD, CMD_REG_FETCH: begin
                        imm_d   = 1'b1;
                        usage_d = USE_READ_ONLY;
                        if (hasP_q && par1_q == 32'(REG_IDX_ACCEL)) begin
                            rspValid_d = 1'b1;
                            rspValue_d = accelReg_q;
                        end else if (hasP_q && par1_q == 32'(REG_IDX_ANALOG)) begin
                            rspValid_d = 1'b1;
                            rspValue_d = 32'(analogCmd_q);
                        end else begin
                            err_d = 1'b1;
                        end
                    end
                    default: begin
                        err_d = 1'b1;
                    end
                endcase
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q                 <= ST_IDLE;
            code_q                  <= 16'h0000;
            hasP_q                  <= 1'b0;
            hasP2_q                 <= 1'b0;
            par1_q                  <= 32'sh0000_0000;
            par2_q                  <= 32'sh0000_0000;
            cmdReady_q              <= 1'b0;
            rspValid_q              <= 1'b0;
            rspCode_q               <= 16'h0000;
            rspValue_q              <= 32'sh0000_0000;
            cmdErr_q                <= 1'b0;
            cmdImmediate_q          <= 1'b0;
            cmdUsage_q              <= USE_READ_WRITE;
            rampRateSetting_q       <= ACC_RESET;
            accelReg_q              <= 32'(ACC_RESET) << ACC_REG_SHIFT;
            inputSmoothingSetting_q <= FILT_RESET;
            db_q                    <= '{default: DB_RESET};
            nvWrite_q               <= 1'b0;
            nvRampRate_q            <= ACC_RESET;
            nvSmoothing_q           <= FILT_RESET;
            nvDeadband_q            <= {NUM_CHAN{DB_RESET}};
            analogCmd_q             <= 17'sh0_0000;
        end else begin
            state_q                 <= state_d;
            code_q                  <= code_d;
            hasP_q                  <= hasP_d;
            hasP2_q                 <= hasP2_d;
            par1_q                  <= par1_d;
            par2_q                  <= par2_d;
            cmdReady_q              <= ready_d;
            rspValid_q              <= rspValid_d;
            rspCode_q               <= rspCode_d;
            rspValue_q              <= rspValue_d;
            cmdErr_q                <= err_d;
            cmdImmediate_q          <= imm_d;
            cmdUsage_q              <= usage_d;
            rampRateSetting_q       <= ramp_d;
            // Data register keeps its own finer units
            accelReg_q              <= 32'(ramp_d) << ACC_REG_SHIFT;
            inputSmoothingSetting_q <= smooth_d;
            db_q                    <= db_d;
            nvWrite_q               <= nvWrite_d;
            // Snapshot only on persist so working edits stay volatile
            if (nvWrite_d) begin
                nvRampRate_q  <= rampRateSetting_q;
                nvSmoothing_q <= inputSmoothingSetting_q;
                nvDeadband_q  <= {db_q[2], db_q[1], db_q[0]};
            end
            // Register mirrors the conditioned first input
            analogCmd_q             <= chanOut[0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_WRITE_SILENT: assert property (
        exec && hasP_q && (code_q == CMD_RAMP || code_q == CMD_SMOOTH
        || code_q == CMD_DEADBAND) |=> !rspValid_q)
        else $error("parameter write produced a reply");

    AST_QUERY_REPLY: assert property (
        exec && !hasP_q && code_q == CMD_RAMP
        |=> rspValid_q && rspCode_q == CMD_RAMP
            && rspValue_q == 32'(rampRateSetting_q))
        else $error("ramp query reply wrong");

    AST_RAMP_RANGE: assert property (
        rampRateSetting_q >= ACC_MIN && rampRateSetting_q <= ACC_MAX)
        else $error("ramp setting out of range");

    AST_ACC_MIRROR: assert property (
        exec && hasP_q && code_q == CMD_RAMP && !err_d
        |=> accelReg_q == (32'(rampRateSetting_q) << ACC_REG_SHIFT)
            && rampRateSetting_q == $past(par1_q[15:0]))
        else $error("acceleration register not updated with ramp");

    AST_REJECT_KEEPS: assert property (
        cmdErr_q |-> rampRateSetting_q == $past(rampRateSetting_q)
            && inputSmoothingSetting_q == $past(inputSmoothingSetting_q)
            && !rspValid_q)
        else $error("rejected command changed a setting");

    AST_SMOOTH_RANGE: assert property (
        inputSmoothingSetting_q <= FILT_MAX)
        else $error("smoothing setting out of range");

    AST_PERSIST_ONLY: assert property (
        !nvWrite_q ##1 !nvWrite_q |-> $stable(nvRampRate_q) && $stable(nvSmoothing_q)
            && $stable(nvDeadband_q))
        else $error("persistent copy changed without persist");

    AST_CHAN_SELECT: assert property (
        exec && code_q == CMD_DEADBAND && hasP2_q && par1_q == 32'sd2 && p2Fits8
        |=> db_q[1] == $past(par2_q[7:0]) && db_q[0] == $past(db_q[0]))
        else $error("channel deadband not stored in selected channel");

    AST_CMD_CLASS: assert property (
        exec && (code_q == CMD_REG_LOAD || code_q == CMD_REG_FETCH)
        |=> cmdImmediate_q && cmdUsage_q == USE_READ_ONLY)
        else $error("register command not classed immediate read-only");

    AST_READY_RETURNS: assert property (
        cmdValid && cmdReady_q |=> !cmdReady_q ##1 cmdReady_q)
        else $error("command handshake timing wrong");
endmodule

//--- tb/dcac_host_model.sv
// Host controller model: offers parsed commands and collects the answer
`timescale 1ns/1ns
module dcac_host_model (
    // Clock
    input  wire logic          clk,
    // Command side
    output logic               cmdValid,
    output logic [15:0]        cmdCode,
    output logic               cmdHasParam,
    output logic               cmdHasParam2,
    output logic signed [31:0] cmdParam1,
    output logic signed [31:0] cmdParam2,
    input  wire logic          cmdReady_q,
    // Answer side
    input  wire logic          rspValid_q,
    input  wire logic          cmdErr_q,
    input  wire logic [31:0]   rspValue_q
);
    initial begin
        {cmdValid, cmdHasParam, cmdHasParam2} = '0;
        {cmdCode, cmdParam1, cmdParam2} = '0;
    end

    task automatic xfer(input logic [15:0] c, input logic h, h2, input int a, b,
                        output logic r, e, output logic [31:0] v);
        @(negedge clk);
        cmdValid = 1'b1;
        cmdCode = c;
        cmdHasParam = h;
        cmdHasParam2 = h2;
        cmdParam1 = a;
        cmdParam2 = b;
        while (cmdReady_q !== 1'b1) begin
            @(negedge clk);
        end
        @(negedge clk);
        // Released code and parameters show garbage so a late sample cannot pass by luck
        cmdValid = 1'b0;
        cmdCode = ~c;
        cmdParam1 = ~a;
        cmdParam2 = ~b;
        // The reply and error pulses stand one cycle, so look at the first falling edge
        @(negedge clk);
        r = rspValid_q;
        e = cmdErr_q;
        v = rspValue_q;
    endtask
endmodule

//--- tb/dcac_cmd_top_tb_top.sv
// Self-checking bench for the drive command interpreter
`timescale 1ns/1ns
module dcac_cmd_top_tb_top
    import dcac_pkg::*;
;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 cmdValid, cmdHasParam, cmdHasParam2, cmdReady_q;
    logic [15:0]          cmdCode, rspCode_q, rampRateSetting_q;
    logic signed [31:0]   cmdParam1, cmdParam2, rspValue_q;
    logic                 rspValid_q, cmdErr_q, cmdImmediate_q, nvWrite_q;
    logic [1:0]           cmdUsage_q;
    logic [7:0]           controlModeSelect;
    logic                 adcValid;
    logic signed [15:0]   adcCh1, adcCh2, zeroPoint;
    logic signed [16:0]   analogCmd_q;
    logic [31:0]          accelReg_q;
    logic [15:0]          inputSmoothingSetting_q, nvRampRate_q, nvSmoothing_q;
    logic [23:0]          nvDeadband_q;
    int                   fail_count = 0;
    int                   check_count = 0;
    int                   lo[3] = '{1, 0, 0};
    int                   hi[3] = '{32701, 255, 32767};
    logic [15:0]          cd[3] = '{CMD_RAMP, CMD_DEADBAND, CMD_SMOOTH};

    always #10 clk = ~clk;

    dcac_cmd_top uut (
        .clk, .rst, .cmdValid, .cmdCode, .cmdHasParam, .cmdHasParam2,
        .cmdParam1, .cmdParam2, .cmdReady_q, .rspValid_q, .rspCode_q,
        .rspValue_q, .cmdErr_q, .cmdImmediate_q, .cmdUsage_q,
        .controlModeSelect, .adcValid, .adcCh1, .adcCh2, .zeroPoint,
        .analogCmd_q, .rampRateSetting_q, .accelReg_q, .inputSmoothingSetting_q,
        .nvWrite_q, .nvRampRate_q, .nvSmoothing_q, .nvDeadband_q
    );

    dcac_host_model host (
        .clk, .cmdValid, .cmdCode, .cmdHasParam, .cmdHasParam2, .cmdParam1,
        .cmdParam2, .cmdReady_q, .rspValid_q, .cmdErr_q, .rspValue_q
    );

    task automatic close_out;
        $display("checks %0d fails %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic ck(input logic [31:0] g, x, input string m);
        check_count++;
        if (g !== x) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, g, x);
        end
    endtask

    // One command; the value is compared only when a reply is expected
    task automatic run(input logic [15:0] c, input logic h, h2, input int a, b,
                       input logic er, ee, input logic [31:0] ev);
        logic        r, e;
        logic [31:0] v;
        host.xfer(c, h, h2, a, b, r, e, v);
        ck({r, e}, {er, ee}, "reply and error flags");
        if (er) begin
            ck(v, ev, "reply value");
        end
    endtask

    // Sample is held one cycle; four more cycles cover the three-edge path
    task automatic samp(input logic signed [15:0] s);
        adcCh1 = s;
        adcCh2 = ~s;
        adcValid = 1'b1;
        @(negedge clk);
        adcValid = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    initial begin
        #100000;
        fail_count++;
        close_out();
    end

    initial begin
        {adcValid, adcCh1, adcCh2, zeroPoint} = '0;
        controlModeSelect = 8'h00;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        ck(rampRateSetting_q, ACC_RESET, "ramp reset");
        ck(accelReg_q, 32'(ACC_RESET) << ACC_REG_SHIFT, "accel reset");
        ck(inputSmoothingSetting_q, FILT_RESET, "smoothing reset");
        ck(nvDeadband_q, '0, "deadband reset");
        run(CMD_RAMP, 0, 0, 0, 0, 1, 0, ACC_RESET);
        ck(rspCode_q, CMD_RAMP, "reply code");
        run(CMD_RAMP, 1, 0, 100, 0, 0, 0, 0);
        ck(accelReg_q, 32'h0000_0190, "accel mirror");
        for (int i = 0; i < 3; i++) begin
            run(cd[i], 1, 0, hi[i], 0, 0, 0, 0);
            run(cd[i], 1, 0, hi[i] + 1, 0, 0, 1, 0);
            run(cd[i], 1, 0, lo[i] - 1, 0, 0, 1, 0);
            run(cd[i], 0, 0, 0, 0, 1, 0, hi[i]);
            run(cd[i], 1, 0, lo[i], 0, 0, 0, 0);
            run(cd[i], 0, 0, 0, 0, 1, 0, lo[i]);
        end
        ck({cmdImmediate_q, cmdUsage_q}, {1'b0, USE_READ_WRITE}, "class rw");
        run(CMD_DEADBAND, 1, 1, 2, 20, 0, 0, 0);
        run(CMD_DEADBAND, 1, 1, 4, 5, 0, 1, 0);
        run(CMD_DEADBAND, 1, 1, 0, 5, 0, 1, 0);
        run(CMD_DEADBAND, 0, 0, 0, 0, 1, 0, 0);
        run(CMD_REG_FETCH, 1, 0, REG_IDX_ACCEL, 0, 1, 0, 4);
        ck({cmdImmediate_q, cmdUsage_q}, {1'b1, USE_READ_ONLY}, "class ro");
        run(CMD_REG_LOAD, 1, 0, REG_IDX_ACCEL, 0, 1, 0, 4);
        run(CMD_REG_FETCH, 1, 0, 200, 0, 0, 1, 0);
        ck(nvRampRate_q, ACC_RESET, "persistent ramp held");
        run(CMD_PERSIST, 0, 0, 0, 0, 0, 0, 0);
        ck(nvWrite_q, 1, "persist strobe");
        ck(nvRampRate_q, 1, "persistent ramp");
        ck(nvDeadband_q, 24'h00_1400, "persistent deadbands");
        ck(cmdUsage_q, USE_WRITE_ONLY, "class wo");
        run(16'h5A5A, 0, 0, 0, 0, 0, 1, 0);
        run(CMD_DEADBAND, 1, 1, 1, 10, 0, 0, 0);
        samp(16'sh0005);
        ck(analogCmd_q, 0, "inside deadband");
        run(CMD_DEADBAND, 1, 1, 1, 0, 0, 0, 0);
        samp(16'sh0005);
        ck(analogCmd_q, 5, "deadband removed");
        controlModeSelect = MODE_ANALOG_POS;
        run(CMD_DEADBAND, 1, 1, 1, 10, 0, 0, 0);
        samp(16'sh0064);
        ck(analogCmd_q, 100, "hysteresis step");
        samp(16'sh006A);
        ck(analogCmd_q, 100, "hysteresis hold");
        controlModeSelect = 8'h00;
        run(CMD_SMOOTH, 1, 0, 16384, 0, 0, 0, 0);
        samp(16'sh03E8);
        // Half-weight pole cannot reach the step in one sample
        ck(analogCmd_q > 106 && analogCmd_q < 1000, 1, "smoothing lag");
        // Full-scale setting must act like the knee value, not like a bypass
        run(CMD_SMOOTH, 1, 0, 32767, 0, 0, 0, 0);
        samp(16'sh03E8);
        ck(analogCmd_q, 938, "smoothing capped above knee");
        run(CMD_PERSIST, 0, 0, 0, 0, 0, 0, 0);
        ck(nvSmoothing_q, 32767, "persistent smoothing");
        close_out();
    end
endmodule
